// ### dbgbu_match.sv
// address comparator of one breakpoint
`timescale 1ns/1ps
module dbgbu_match
    import dbgbu_pkg::*;
(
    // breakpoint setup
    input  wire logic [31:0] bkpt_addr,
    input  wire logic [1:0]  len_field,
    input  wire logic [1:0]  rw_field,
    // current accesses
    input  wire logic [31:0] ifetch_addr,
    input  wire logic [29:0] dacc_dword,
    input  wire logic [3:0]  dacc_be,
    input  wire logic        dacc_write,
    // condition outputs
    output logic             inst_hit,
    output logic             data_hit
);
    logic [3:0] field_be;

    // bytes of the aligned dword covered by the breakpoint field
    always_comb
    begin
        unique case (len_field)
            LEN_1:   field_be = 4'h1 << bkpt_addr[1:0];
            LEN_2:   field_be = bkpt_addr[1] ? 4'hC : 4'h3;
            LEN_4:   field_be = 4'hF;
            default: field_be = 4'h0;                                  // undefined length never matches
        endcase
    end

    // execution match on exact start address, data match on any overlap
    always_comb
    begin
        inst_hit = (rw_field == RW_EXEC) && (len_field == LEN_1)
                   && (ifetch_addr == bkpt_addr);
        data_hit = (dacc_dword == bkpt_addr[31:2]) && ((field_be & dacc_be) != 4'h0)
                   && ((rw_field == RW_RDWR) || ((rw_field == RW_WRITE) && dacc_write));
    end

endmodule

// ### dbgbu_pkg.sv
// constants and carrier types of the debug breakpoint unit
package dbgbu_pkg;

    // geometry
    localparam int BKPT_NUM = 4;

    // register byte offsets on the apb
    localparam logic [7:0] OFF_BKPT0   = 8'h00;
    localparam logic [7:0] OFF_BKPT3   = 8'h0C;
    localparam logic [7:0] OFF_STATUS  = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h1C;

    // debug_control fields: local enable at 2i, global enable at 2i+1
    localparam int CTRL_LOCAL_EXACT  = 8;
    localparam int CTRL_GLOBAL_EXACT = 9;
    localparam int CTRL_GUARD        = 13;
    localparam int CTRL_RW_LSB       = 16;
    localparam int CTRL_LEN_LSB      = 18;
    localparam int CTRL_FIELD_STRIDE = 4;
    localparam logic [31:0] CTRL_WMASK  = 32'hFFFF_23FF;
    localparam logic [31:0] CTRL_LOCALS = 32'h0000_0155;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

    // debug_status fields: breakpoint hit flag i at bit i
    localparam int STAT_GUARD_HIT  = 13;
    localparam int STAT_STEP_TRAP  = 14;
    localparam int STAT_SWITCH_TRAP = 15;
    localparam logic [31:0] STAT_WMASK = 32'h0000_E00F;
    localparam logic [31:0] STAT_RESET = 32'h0000_0000;

    // access type and length encodings
    localparam logic [1:0] RW_EXEC  = 2'h0;
    localparam logic [1:0] RW_WRITE = 2'h1;
    localparam logic [1:0] RW_RDWR  = 2'h3;
    localparam logic [1:0] LEN_1    = 2'h0;
    localparam logic [1:0] LEN_2    = 2'h1;
    localparam logic [1:0] LEN_4    = 2'h3;

    // events presented by the core pipeline on the same clock
    typedef struct packed {
        logic        ifetch_valid;     // instruction about to execute
        logic [31:0] ifetch_addr;      // its linear start address
        logic        dacc_valid;       // data operand transfer done
        logic        dacc_write;
        logic [29:0] dacc_dword;       // linear dword address
        logic [3:0]  dacc_be;          // bytes touched in that dword
        logic        retire;           // instruction completes
        logic        trap_step_flag;   // flag register single-step bit
        logic        task_switch;      // switch to new task_state_record
        logic        task_trap;        // debug-trap bit of new record
        logic        exc_entry;        // debug exception handler entered
        logic        resume_suppress_flag;
        logic        priv_ok;          // real mode or privilege level 0
    } dbgbu_core_ev_type;

    // whole state of the top module
    typedef struct packed {
        logic [BKPT_NUM-1:0][31:0] bkpt_addr;
        logic [31:0]               ctrl;
        logic [31:0]               status;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
        logic                      fault;
        logic                      trap;
        logic                      stall;
    } dbgbu_state_type;

endpackage

// ### dbgbu_top.sv
// debug breakpoint unit: breakpoint registers, control, status and exception requests
//
// Functional notes
// - guard bit set: any debug register access raises a debug fault; the code raises it only for accesses with priv_ok set
// - entering the debug handler clears the guard bit
// - exact match on: stall next instruction until data transfers finish
// - task switch clears the local exact match bit
// - task switch keeps the global exact match bit
// - execution breakpoints are always reported exactly
// - breakpoint enabled by global or local bit; enabled hit calls handler
// - task switch clears all four local enable bits
// - task switch keeps all global enable bits
// - hardware only sets status flags; software clears them
// - execution hit is a fault, data hit is a trap
// - on an enabled hit, flag every matching breakpoint, enabled or not
// - guard hit flag set on a guarded debug register access
// - single-step flag set when the trap-step flag causes the trap
// - switch into task with debug-trap bit: trap afterwards, switch flag set
// - resume suppress flag hides an execution breakpoint
// - access type: 00 execute, 01 write, 11 read or write
// - length 1, 2 or 4 aligned bytes by ignoring low address bits
// - data hit when an access touches any byte of the field
// - debug registers reachable only in real mode or privilege level 0
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module dbgbu_top
    import dbgbu_pkg::*;
(
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // core pipeline events
    input  wire dbgbu_core_ev_type core_ev,
    // exception requests and exact-match stall to the core
    output logic                   exc_fault,
    output logic                   exc_trap,
    output logic                   stall_next
);
    dbgbu_state_type     st_ff;
    dbgbu_state_type     nxt_st;
    logic [BKPT_NUM-1:0] inst_hit;
    logic [BKPT_NUM-1:0] data_hit;
    logic [BKPT_NUM-1:0] bkpt_en;
    logic                apb_acc;
    logic                apb_done;
    logic                guard_fault;
    logic                inst_evt;
    logic                data_evt;
    logic                step_evt;
    logic                switch_evt;
    logic                exact_on;
    logic [31:0]         status_set;
    logic [31:0]         rd_word;

    //------------------------------------------------------------------
    // per-breakpoint enable and comparators
    //------------------------------------------------------------------
    for (genvar i = 0; i < BKPT_NUM; i++)
    begin : g_bkpt
        assign bkpt_en[i] = st_ff.ctrl[2*i] | st_ff.ctrl[2*i+1];
        dbgbu_match u_match (
            .bkpt_addr   (st_ff.bkpt_addr[i]),
            .len_field   (st_ff.ctrl[CTRL_LEN_LSB+CTRL_FIELD_STRIDE*i +: 2]),
            .rw_field    (st_ff.ctrl[CTRL_RW_LSB+CTRL_FIELD_STRIDE*i +: 2]),
            .ifetch_addr (core_ev.ifetch_addr),
            .dacc_dword  (core_ev.dacc_dword),
            .dacc_be     (core_ev.dacc_be),
            .dacc_write  (core_ev.dacc_write),
            .inst_hit    (inst_hit[i]),
            .data_hit    (data_hit[i])
        );
    end

    //------------------------------------------------------------------
    // event decode
    //------------------------------------------------------------------
    // access phase first cycle, and completing cycle of an apb transfer
    assign apb_acc     = psel && penable && !st_ff.pready;
    assign apb_done    = psel && penable && st_ff.pready && !st_ff.pslverr;
    assign guard_fault = apb_acc && core_ev.priv_ok && st_ff.ctrl[CTRL_GUARD];
    assign inst_evt    = core_ev.ifetch_valid && !core_ev.resume_suppress_flag
                         && ((inst_hit & bkpt_en) != '0);
    assign data_evt    = core_ev.dacc_valid && ((data_hit & bkpt_en) != '0);
    assign step_evt    = core_ev.retire && core_ev.trap_step_flag;
    assign switch_evt  = core_ev.task_switch && core_ev.task_trap;
    assign exact_on    = st_ff.ctrl[CTRL_GLOBAL_EXACT] | st_ff.ctrl[CTRL_LOCAL_EXACT];

    // flags raised this cycle; on an enabled hit every matching breakpoint is flagged
    always_comb
    begin
        status_set = '0;
        if (inst_evt)
            status_set[BKPT_NUM-1:0] = status_set[BKPT_NUM-1:0] | inst_hit;
        if (data_evt)
            status_set[BKPT_NUM-1:0] = status_set[BKPT_NUM-1:0] | data_hit;
        status_set[STAT_GUARD_HIT]   = guard_fault;
        status_set[STAT_STEP_TRAP]   = step_evt;
        status_set[STAT_SWITCH_TRAP] = switch_evt;
    end

    // read data of the addressed register, unmapped reads as zero
    always_comb
    begin
        rd_word = '0;
        if (paddr <= OFF_BKPT3 && paddr[1:0] == 2'h0)
            rd_word = st_ff.bkpt_addr[paddr[3:2]];
        else if (paddr == OFF_STATUS)
            rd_word = st_ff.status;
        else if (paddr == OFF_CONTROL)
            rd_word = st_ff.ctrl;
    end

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        // apb access phase: answer one cycle later
        if (apb_acc)
        begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !core_ev.priv_ok || st_ff.ctrl[CTRL_GUARD];
            nxt_st.prdata  = (core_ev.priv_ok && !st_ff.ctrl[CTRL_GUARD]) ? rd_word : 32'h0000_0000;
        end
        // writes land on the completing edge of an accepted transfer
        if (apb_done && pwrite)
        begin
            if (paddr <= OFF_BKPT3 && paddr[1:0] == 2'h0)
                nxt_st.bkpt_addr[paddr[3:2]] = pwdata;
            else if (paddr == OFF_CONTROL)
                nxt_st.ctrl = pwdata & CTRL_WMASK;
            else if (paddr == OFF_STATUS)
                nxt_st.status = pwdata & STAT_WMASK;
        end
        // hardware sets win over a software clear in the same cycle
        nxt_st.status = nxt_st.status | status_set;
        // task switch drops task-local enables and local exact match
        if (core_ev.task_switch)
            nxt_st.ctrl = nxt_st.ctrl & ~CTRL_LOCALS;
        // handler entry frees the debug registers
        if (core_ev.exc_entry)
            nxt_st.ctrl[CTRL_GUARD] = 1'b0;
        // exception requests and exact-match stall
        nxt_st.fault = inst_evt || guard_fault;
        nxt_st.trap  = data_evt || step_evt || switch_evt;
        nxt_st.stall = core_ev.dacc_valid && exact_on;
    end

    //------------------------------------------------------------------
    // state register
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff           <= '0;
            st_ff.ctrl      <= CTRL_RESET;
            st_ff.status    <= STAT_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from the state flops
    assign prdata     = st_ff.prdata;
    assign pready     = st_ff.pready;
    assign pslverr    = st_ff.pslverr;
    assign exc_fault  = st_ff.fault;
    assign exc_trap   = st_ff.trap;
    assign stall_next = st_ff.stall;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic status_wr;
    assign status_wr = apb_done && pwrite && paddr == OFF_STATUS;

    sequence s_guarded_access;
        psel && penable && !pready && core_ev.priv_ok && st_ff.ctrl[CTRL_GUARD];
    endsequence

    sequence s_refused_answer;
        pready && pslverr && exc_fault && st_ff.status[STAT_GUARD_HIT];
    endsequence

    AST_GUARD_FAULT: assert property (s_guarded_access |=> s_refused_answer)
        else $error("guarded debug register access not refused with fault");
    AST_GUARD_FLAG: assert property (s_guarded_access |=> ##[0:2] st_ff.status[STAT_GUARD_HIT])
        else $error("guard hit flag not set");
    AST_GUARD_CLEAR: assert property (core_ev.exc_entry |=> !st_ff.ctrl[CTRL_GUARD])
        else $error("guard bit survived handler entry");
    AST_EXACT_STALL: assert property (core_ev.dacc_valid && exact_on |=> stall_next)
        else $error("no stall with exact match on");
    AST_LOCAL_CLEAR: assert property (core_ev.task_switch |=> (st_ff.ctrl & CTRL_LOCALS) == '0)
        else $error("local enables survived task switch");
    AST_GLOBAL_KEEP: assert property (core_ev.task_switch && !apb_done && !core_ev.exc_entry
        |=> (st_ff.ctrl & ~CTRL_LOCALS) == ($past(st_ff.ctrl) & ~CTRL_LOCALS))
        else $error("global bits changed on task switch");
    // a lone execution hit gives a fault and no trap; other events may add a trap
    AST_INST_FAULT: assert property (inst_evt && !data_evt && !step_evt && !switch_evt
        |=> exc_fault && !exc_trap)
        else $error("execution breakpoint not reported as fault");
    AST_DATA_TRAP: assert property (data_evt |=> exc_trap)
        else $error("data breakpoint not reported as trap");
    AST_HIT_FLAGS: assert property (inst_evt && !data_evt
        |=> (st_ff.status[BKPT_NUM-1:0] & $past(inst_hit)) == $past(inst_hit))
        else $error("matching breakpoint flag missing");
    AST_STEP_FLAG: assert property (step_evt |=> exc_trap && st_ff.status[STAT_STEP_TRAP])
        else $error("single-step trap not flagged");
    AST_SWITCH_TRAP: assert property (switch_evt |=> exc_trap && st_ff.status[STAT_SWITCH_TRAP])
        else $error("task switch trap not flagged");
    AST_RESUME: assert property (core_ev.ifetch_valid && core_ev.resume_suppress_flag && !guard_fault
        |=> !exc_fault)
        else $error("suppressed breakpoint still faulted");
    AST_PRIV: assert property (psel && penable && !pready && !core_ev.priv_ok |=> pready && pslverr)
        else $error("unprivileged access not refused");
    AST_STICKY: assert property (!status_wr
        |=> (st_ff.status & $past(st_ff.status)) == $past(st_ff.status))
        else $error("status flag cleared by hardware");

endmodule

// ### dbgbu_top_test.sv
// self-checking testbench of the debug breakpoint unit
`timescale 1ns/1ps
module dbgbu_top_test;
    import dbgbu_pkg::*;

    `define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
        $display("FAIL %s expected %0h seen %0h", name, exp, got); end end

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } dbgbu_row_type;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    dbgbu_core_ev_type core_ev;
    dbgbu_core_ev_type idle_ev;
    dbgbu_core_ev_type e;
    logic              exc_fault;
    logic              exc_trap;
    logic              stall_next;
    logic [31:0]       rdv;
    logic              errv;
    logic              fltv;
    int                failures;
    int                cmp_count;
    dbgbu_row_type     rows [7];

    dbgbu_top u_dbgbu_top (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .core_ev    (core_ev),
        .exc_fault  (exc_fault),
        .exc_trap   (exc_trap),
        .stall_next (stall_next)
    );

    // 250 MHz clock
    always #2 pclk = ~pclk;

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    // one apb transfer; answer taken once pready is seen high, before the edge that samples it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look at pready once it has settled after each edge
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // answer stands until the edge that samples it
        rdv  = prdata;
        errv = pslverr;
        fltv = exc_fault;
        if (n >= 20) failures++;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle core event, outputs settled afterwards
    task automatic pulse(input dbgbu_core_ev_type ev);
        @(posedge pclk);
        core_ev <= ev;
        @(posedge pclk);
        core_ev <= idle_ev;
        #1;
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #40000;
        failures++;
        tally_and_finish();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        idle_ev = '0;
        idle_ev.priv_ok = 1'b1;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; core_ev = idle_ev; failures = 0; cmp_count = 0;
        rows[0] = '{OFF_BKPT0, 32'h1234_5679, 32'h1234_5679};
        rows[1] = '{OFF_BKPT3, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
        rows[2] = '{OFF_CONTROL, 32'hFFFF_DFFF, 32'hFFFF_03FF};
        rows[3] = '{OFF_STATUS, 32'hFFFF_FFFF, STAT_WMASK};
        rows[4] = '{8'h10, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[5] = '{OFF_CONTROL, 32'h0000_0000, 32'h0000_0000};
        rows[6] = '{OFF_STATUS, 32'h0000_0000, 32'h0000_0000};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CONTROL, 32'h0);
        `CHK("control after reset", CTRL_RESET, rdv)
        // register rows: write then read back
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            apb(1'b0, rows[i].addr, 32'h0);
            `CHK("register readback", rows[i].exp, rdv)
        end
        // execution breakpoint 0, global enable
        apb(1'b1, OFF_BKPT0, 32'h0000_2000);
        apb(1'b1, OFF_CONTROL, 32'h0000_0002);
        e = idle_ev; e.ifetch_valid = 1'b1; e.ifetch_addr = 32'h0000_2000;
        pulse(e);
        `CHK("exec fault", 2'b10, {exc_fault, exc_trap})
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("exec hit flag", 32'h0000_0001, rdv)
        e.resume_suppress_flag = 1'b1;
        pulse(e);
        `CHK("suppressed exec", 1'b0, exc_fault)
        // data breakpoints: 1 enabled write dword, 2 disabled byte read/write
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_BKPT0 + 8'h04, 32'h0000_1005);
        apb(1'b1, OFF_BKPT0 + 8'h08, 32'h0000_1004);
        apb(1'b1, OFF_CONTROL, 32'h03D0_0204);
        e = idle_ev; e.dacc_valid = 1'b1; e.dacc_write = 1'b1; e.dacc_dword = 30'h0000_0401;
        e.dacc_be = 4'h1;
        pulse(e);
        `CHK("data trap", 3'b011, {exc_fault, exc_trap, stall_next})
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("hit flags", 32'h0000_0006, rdv)
        e.dacc_write = 1'b0;
        pulse(e);
        `CHK("read on write-only", 1'b0, exc_trap)
        e.dacc_write = 1'b1; e.dacc_dword = 30'h0000_0402;
        pulse(e);
        `CHK("access outside field", 1'b0, exc_trap)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("flags kept", 32'h0000_0006, rdv)
        // two-byte write field at 0x3002: bytes 2 and 3 of its dword only
        apb(1'b1, OFF_BKPT3, 32'h0000_3003);
        apb(1'b1, OFF_CONTROL, 32'h5000_0280);
        e = idle_ev;
        e.dacc_valid = 1'b1;
        e.dacc_write = 1'b1;
        e.dacc_dword = 30'h0000_0C00;
        e.dacc_be = 4'h4;
        pulse(e);
        `CHK("word field hit", 1'b1, exc_trap)
        e.dacc_be = 4'h2;
        pulse(e);
        `CHK("word field miss", 1'b0, exc_trap)
        // task switch into a trapping task
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CONTROL, 32'h0000_03FF);
        e = idle_ev; e.task_switch = 1'b1; e.task_trap = 1'b1;
        pulse(e);
        `CHK("switch trap", 1'b1, exc_trap)
        apb(1'b0, OFF_CONTROL, 32'h0);
        `CHK("locals cleared", 32'h0000_02AA, rdv)
        `CHK("global exact kept", 1'b1, rdv[CTRL_GLOBAL_EXACT])
        `CHK("local exact cleared", 1'b0, rdv[CTRL_LOCAL_EXACT])
        `CHK("globals kept", 4'hF, {rdv[7], rdv[5], rdv[3], rdv[1]})
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("switch flag", 32'h0000_8000, rdv)
        // single step
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CONTROL, 32'h0);
        e = idle_ev; e.retire = 1'b1; e.trap_step_flag = 1'b1;
        pulse(e);
        `CHK("step trap", 1'b1, exc_trap)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("step flag", 32'h0000_4000, rdv)
        // guard bit traps register access until the handler is entered
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CONTROL, 32'h0000_2000);
        apb(1'b0, OFF_CONTROL, 32'h0);
        `CHK("guarded access", 34'h2_0000_0000 | 34'h1_0000_0000 >> 0, {errv, fltv, rdv})
        e = idle_ev; e.exc_entry = 1'b1;
        pulse(e);
        apb(1'b0, OFF_CONTROL, 32'h0);
        `CHK("guard cleared", 33'h0_0000_0000, {errv, rdv})
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("guard hit flag", 32'h0000_2000, rdv)
        // privilege refusal
        @(posedge pclk);
        core_ev.priv_ok <= 1'b0;
        apb(1'b1, OFF_BKPT0, 32'h0000_0055);
        `CHK("unprivileged write", 1'b1, errv)
        core_ev.priv_ok <= 1'b1;
        apb(1'b0, OFF_BKPT0, 32'h0);
        `CHK("write dropped", 32'h0000_2000, rdv)
        // reset in mid-run clears control
        apb(1'b1, OFF_CONTROL, 32'h0000_0303);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CONTROL, 32'h0);
        `CHK("control after second reset", CTRL_RESET, rdv)
        tally_and_finish();
    end
endmodule
